// file: design/pc_stack_cfg.svh
// Constants for the program counter and return stack
`ifndef PC_STACK_CFG_SVH
`define PC_STACK_CFG_SVH
`define PC_WIDTH        13
`define PC_LOW_W        8
`define PC_UPPER_W      5
`define JUMP_FIELD_W    11
`define STACK_DEPTH     8
`define STACK_PTR_W     3
`define ADDR_W          9
`define PC_LOW_OFFSET   9'h102
`define PC_LATCH_OFFSET 9'h10a
`define PC_RESET        13'h0000
`define LATCH_RESET     5'h00
`define INT_VECTOR      13'h0004
`endif

// file: design/pc_stack_pkg.sv
// Types for the program counter and return stack
package pc_stack_pkg;
  typedef logic [12:0] pc_t;
  typedef enum logic [5:0] {
    SEQ_STEP   = 6'h01,
    SEQ_JUMP   = 6'h02,
    SEQ_CALL   = 6'h04,
    SEQ_RETURN = 6'h08,
    SEQ_IRQ    = 6'h10,
    SEQ_HOLD   = 6'h20
  } seq_op_e;
endpackage : pc_stack_pkg

// file: design/program_counter_and_call_stack.sv
// Program counter sequencing with circular hardware return stack
// Operation
// RULE_01: Counter is 13 bits; low byte is a readable, writable register.
// RULE_02: Upper five counter bits have no direct access; loaded from latch.
// RULE_03: Every reset clears the whole program counter to zero.
// RULE_04: Writing the low byte loads latch bits 4:0 into upper bits; the write is dropped if a sequencing event occurs in the same cycle.
// RULE_05: Call or goto loads latch bits 4:3 into counter bits 12:11.
// RULE_06: Low byte wrap from 0xff to 0x00 never carries into latch.
// RULE_07: Return stack holds eight 13-bit entries, outside program/data space.
// RULE_08: Stack pointer cannot be read or written by instructions.
// RULE_09: Call and interrupt vectoring push the counter onto the stack.
// RULE_10: Return, return-with-literal, return-from-interrupt pop into counter.
// RULE_11: Push and pop leave the high-byte latch unchanged.
// RULE_12: Stack is circular; ninth push overwrites the first entry.
// RULE_13: No overflow or underflow status exists.
// RULE_14: Call/goto take low eleven bits from instruction; else count by one.
// RULE_15: Pushed value is the next instruction's address.
`timescale 1ns/1ps
`include "pc_stack_cfg.svh"
module program_counter_and_call_stack
  import pc_stack_pkg::*;
#(
  parameter logic [12:0] INT_VECTOR = `INT_VECTOR
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic        step_i,
  input  wire logic        goto_i,
  input  wire logic        call_i,
  input  wire logic        return_i,
  input  wire logic        irq_vector_i,
  input  wire logic [10:0] jump_addr_i,
  input  wire logic [8:0]  addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  output logic      [12:0] fetch_addr_o
);

  pc_t                           pc;
  pc_t                           next_pc;
  logic [`PC_UPPER_W-1:0]        pc_high_latch;
  logic [`STACK_PTR_W-1:0]       stack_ptr;  // Internal only, no read path RULE_08
  pc_t                           stack_mem [`STACK_DEPTH];  // RULE_07
  seq_op_e                       op;
  logic                          low_wr;
  logic                          latch_wr;

  // Register decode shared by several processes
  function automatic logic hit(input logic [8:0] a, input logic [8:0] off);
    hit = (a == off);
  endfunction : hit

  assign low_wr   = wr_i && hit(addr_i, `PC_LOW_OFFSET);
  assign latch_wr = wr_i && hit(addr_i, `PC_LATCH_OFFSET);

  // Decoder events are exclusive; priority guards against misuse
  always_comb begin
    if (irq_vector_i) begin
      op = SEQ_IRQ;
    end else if (call_i) begin
      op = SEQ_CALL;
    end else if (goto_i) begin
      op = SEQ_JUMP;
    end else if (return_i) begin
      op = SEQ_RETURN;
    end else if (step_i) begin
      op = SEQ_STEP;
    end else begin
      op = SEQ_HOLD;
    end
  end

  // Next counter value per sequencing event
  always_comb begin
    next_pc = pc;
    case (op)
      SEQ_STEP:   next_pc = pc_t'(pc + 13'h0001);  // RULE_14
      SEQ_JUMP,
      SEQ_CALL:   next_pc = {pc_high_latch[4:3], jump_addr_i};  // RULE_05 RULE_14
      SEQ_RETURN: next_pc = stack_mem[stack_ptr - 3'h1];  // RULE_10
      SEQ_IRQ:    next_pc = INT_VECTOR;
      SEQ_HOLD:   next_pc = pc;
      default:    next_pc = pc;
    endcase
    // A low-byte write with no sequencing event replaces the whole counter; computed result
    // only, so a wrapped add never carries into the latch
    if (low_wr && op == SEQ_HOLD) begin
      next_pc = {pc_high_latch, wdata_i};  // RULE_04 RULE_06 RULE_02
    end
  end

  // Counter register
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc <= `PC_RESET;  // RULE_03
    end else begin
      pc <= next_pc;  // RULE_01
    end
  end

  // High-byte latch; only software writes move it
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pc_high_latch <= `LATCH_RESET;
    end else if (latch_wr) begin
      pc_high_latch <= wdata_i[4:0];  // RULE_11
    end
  end

  // Stack pointer wraps silently, no flags kept
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      stack_ptr <= '0;
    end else if (op == SEQ_CALL || op == SEQ_IRQ) begin
      stack_ptr <= stack_ptr + 3'h1;  // RULE_12 RULE_13
    end else if (op == SEQ_RETURN) begin
      stack_ptr <= stack_ptr - 3'h1;  // RULE_12 RULE_13
    end
  end

  // Stack storage; contents are not reset, like real stack RAM
  always_ff @(posedge ref_clk_i) begin
    if (op == SEQ_CALL || op == SEQ_IRQ) begin
      // Call: push counter plus one, past the call; irq: counter as resume point
      stack_mem[stack_ptr] <= (op == SEQ_CALL) ?
        pc_t'(pc + 13'h0001) : pc;  // RULE_09 RULE_15
    end
  end

  // Read data, one cycle after strobe; unmapped reads zero
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i && hit(addr_i, `PC_LOW_OFFSET)) begin
      rdata_o <= pc[7:0];  // RULE_01
    end else if (rd_i && hit(addr_i, `PC_LATCH_OFFSET)) begin
      rdata_o <= {3'h0, pc_high_latch};
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // Fetch address from its own flop, loaded with next_pc like the counter
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fetch_addr_o <= `PC_RESET;
    end else begin
      fetch_addr_o <= next_pc;
    end
  end

endmodule : program_counter_and_call_stack

// file: verif/decoder_model.sv
// Decoder model issuing one sequencing pulse per edge
`timescale 1ns/1ps
module decoder_model (
  input  wire logic        ref_clk_i,
  output logic      [4:0]  op_o,
  output logic      [10:0] jump_o
);
  initial begin op_o = 5'h00; jump_o = 11'h000; end
  // Held one edge; caller issues idle after
  task automatic issue(input logic [4:0] k, input logic [10:0] a);
    op_o <= k;
    jump_o <= a;
    @(posedge ref_clk_i);
  endtask : issue
endmodule : decoder_model

// file: verif/pc_stack_chk.sv
// Port checker for program counter and return stack
`timescale 1ns/1ps
module pc_stack_chk #(parameter logic [12:0] INT_VECTOR = 13'h004) (
  input wire logic        ref_clk_i, rst_i, step_i, goto_i, call_i,
  input wire logic        return_i, irq_vector_i, wr_i, rd_i,
  input wire logic [10:0] jump_addr_i,
  input wire logic [8:0]  addr_i,
  input wire logic [7:0]  wdata_i, rdata_o,
  input wire logic [12:0] fetch_addr_o
);
  logic [4:0]  lat;
  logic [12:0] tgt;
  logic [7:0]  pc_low_byte;
  logic        ev;
  // Latch has no port, so shadow it from writes
  always_ff @(posedge ref_clk_i or posedge rst_i)
    if (rst_i) lat <= 5'h00;
    else if (wr_i && addr_i == 9'h10a) lat <= wdata_i[4:0];
  assign tgt = {lat[4:3], jump_addr_i};
  assign pc_low_byte = fetch_addr_o[7:0];
  assign ev = step_i | goto_i | call_i | return_i | irq_vector_i;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  property p_step; step_i && !(ev & !step_i) |=>
    fetch_addr_o == $past(fetch_addr_o) + 13'h1; endproperty
  property p_jump; (goto_i || call_i) && !irq_vector_i |=>
    fetch_addr_o == $past(tgt); endproperty
  property p_irq; irq_vector_i |=> fetch_addr_o == INT_VECTOR; endproperty
  property p_wr; wr_i && addr_i == 9'h102 && !ev |=>
    fetch_addr_o == {$past(lat), $past(wdata_i)}; endproperty
  property p_hold; !ev && !(wr_i && addr_i == 9'h102) |=>
    $stable(fetch_addr_o); endproperty
  property p_rdlat; rd_i && addr_i == 9'h10a |=>
    rdata_o == {3'h0, $past(lat)}; endproperty
  property p_rdlow; rd_i && addr_i == 9'h102 |=> rdata_o == $past(pc_low_byte);
  endproperty
  property p_rdz; !rd_i |=> rdata_o == 8'h00; endproperty
  a_step: assert property (p_step) else $error("bad step");
  a_jump: assert property (p_jump) else $error("bad jump");
  a_irq: assert property (p_irq) else $error("bad vector");
  a_wr: assert property (p_wr) else $error("bad low write");
  a_hold: assert property (p_hold) else $error("pc moved");
  a_rdlat: assert property (p_rdlat) else $error("bad latch");
  a_rdlow: assert property (p_rdlow) else $error("bad low read");
  a_rdz: assert property (p_rdz) else $error("stray read data");
  c_call: cover property (call_i);
  c_ret: cover property (return_i);
  c_irq: cover property (irq_vector_i);
endmodule : pc_stack_chk
bind program_counter_and_call_stack pc_stack_chk
  #(.INT_VECTOR(INT_VECTOR)) chk (.*);

// file: verif/tb.sv
// Testbench for program counter and return stack
`timescale 1ns/1ps
module tb;
  logic ref_clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0;
  logic [8:0]  addr_i = 9'h000;
  logic [7:0]  wdata_i = 8'h00, rdata_o;
  logic [12:0] fetch_addr_o;
  logic [4:0]  op;
  logic [10:0] ja;
  int errors = 0, check_count = 0;
  always #10 ref_clk_i = ~ref_clk_i;
  decoder_model dec (.ref_clk_i(ref_clk_i), .op_o(op), .jump_o(ja));
  program_counter_and_call_stack dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .step_i(op[0]), .goto_i(op[1]), .call_i(op[2]), .return_i(op[3]),
    .irq_vector_i(op[4]), .jump_addr_i(ja), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .fetch_addr_o(fetch_addr_o));
  task automatic chk(input logic [12:0] s, input logic [12:0] e);
    check_count++;
    if (s !== e) begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, s, e);
    end
  endtask : chk
  // Pulse then idle, so the counter stands when compared
  task automatic op_chk(input logic [4:0] k, input logic [10:0] a,
                        input logic [12:0] e);
    dec.issue(k, a);
    dec.issue(5'h00, 11'h000);
    chk(fetch_addr_o, e);
  endtask : op_chk
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
    @(posedge ref_clk_i); wr_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : wr
  // Read data stand only in the next cycle
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge ref_clk_i); rd_i <= 1'b0;
    #1 chk(rdata_o, e);
    @(posedge ref_clk_i);
  endtask : rd
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    chk(fetch_addr_o, 13'h0000);
    wr(9'h10a, 8'h01);
    wr(9'h102, 8'h20);
    chk(fetch_addr_o, 13'h0120);
    for (int i = 1; i < 10; i++) op_chk(5'h04, i[10:0], i[12:0]);
    for (int i = 0; i < 9; i++)
      op_chk(5'h08, 11'h000, 13'(i == 8 ? 9 : 9 - i));
    rd(9'h102, 8'h09);
    rd(9'h10a, 8'h01);
    $display("stack test done");
    wr(9'h10a, 8'h18);
    op_chk(5'h02, 11'h7ff, 13'h1fff);
    op_chk(5'h10, 11'h000, 13'h0004);
    op_chk(5'h08, 11'h000, 13'h1fff);
    op_chk(5'h01, 11'h000, 13'h0000);
    wr(9'h102, 8'h00);
    chk(fetch_addr_o, 13'h1800);
    wr(9'h10a, 8'hff);
    rd(9'h10a, 8'h1f);
    rd(9'h103, 8'h00);
    rst_i <= 1'b1;
    @(posedge ref_clk_i);
    chk(fetch_addr_o, 13'h0000);
    rst_i <= 1'b0;
    $display("jump and reset tests done");
    end_sim();
  end
endmodule : tb
